// *** design/fus_status.sv ***
// Status flags, error counts and FIFO counts of a FIFO serial port, reached over APB
`timescale 1ns/1ps
`default_nettype none
`include "fus_defs.svh"
module fus_status (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic standby,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_line,
  input wire logic rx_frame,
  input wire logic [7:0] rx_data,
  input wire logic rx_parity,
  input wire logic rx_first_stop,
  input wire logic rx_idle_tick,
  input wire logic [7:0] rx_fifo_rdata,
  output logic rx_push,
  output logic [7:0] rx_push_data,
  output logic rx_pop,
  input wire logic tx_load,
  input wire logic tx_done,
  output logic tx_push,
  output logic [7:0] tx_push_data,
  output logic rx_enable,
  output logic tx_fifo_low
);
  import fus_pkg::*;

  fus_state_type s_q, s_d;

  logic [4:0] rx_cnt, fe_cnt, pe_cnt;
  logic head_fe, head_pe;
  logic acc, wr_done, rd_done, setup;
  logic tx_wr, tx_take, tx_dec;
  logic [4:0] tx_next, tx_lvl, rx_lvl;
  logic frame_ok, fe, pe, brk_now, suppress;
  logic [7:0] set_v, clr_v;
  logic [15:0] status_view;

  function automatic logic [4:0] fus_tx_level(input logic [1:0] sel);
    logic [4:0] lvl;
    lvl = `FUS_TTRG_L0;
    unique case (sel)
      2'd0: lvl = `FUS_TTRG_L0;
      2'd1: lvl = `FUS_TTRG_L1;
      2'd2: lvl = `FUS_TTRG_L2;
      2'd3: lvl = `FUS_TTRG_L3;
    endcase
    return lvl;
  endfunction

  function automatic logic [4:0] fus_rx_level(input logic [1:0] sel);
    logic [4:0] lvl;
    lvl = `FUS_RTRG_L0;
    unique case (sel)
      2'd0: lvl = `FUS_RTRG_L0;
      2'd1: lvl = `FUS_RTRG_L1;
      2'd2: lvl = `FUS_RTRG_L2;
      2'd3: lvl = `FUS_RTRG_L3;
    endcase
    return lvl;
  endfunction

  // the 4-bit count fields cannot show a full FIFO of errors, so they stick at 15
  function automatic logic [3:0] fus_sat(input logic [4:0] c);
    return c[4] ? 4'hf : c[3:0];
  endfunction

  function automatic logic fus_mapped(input logic [7:0] a);
    return (a == `FUS_ADDR_STATUS) || (a == `FUS_ADDR_COUNT) || (a == `FUS_ADDR_CONFIG) ||
           (a == `FUS_ADDR_TXDATA) || (a == `FUS_ADDR_RXDATA);
  endfunction

  fus_err_tags u_tags (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .flush(standby),
    .push(s_q.rx_push),
    .push_fe(s_q.rx_push_fe),
    .push_pe(s_q.rx_push_pe),
    .pop(s_q.rx_pop),
    .count(rx_cnt),
    .fe_count(fe_cnt),
    .pe_count(pe_cnt),
    .head_fe(head_fe),
    .head_pe(head_pe)
  );

  // bus: one wait state, the transfer completes on the edge that sees pready high
  assign setup = ce & psel & penable & ~s_q.pready;
  assign acc = ce & psel & penable & s_q.pready;
  assign wr_done = acc & pwrite;
  assign rd_done = acc & ~pwrite;

  assign tx_lvl = fus_tx_level(s_q.cfg[1:0]);
  assign rx_lvl = fus_rx_level(s_q.cfg[3:2]);

  assign tx_wr = wr_done & (paddr == `FUS_ADDR_TXDATA);
  assign tx_take = tx_wr & (s_q.tx_cnt < `FUS_FIFO_DEPTH);
  assign tx_dec = ce & tx_load & (s_q.tx_cnt != 5'd0);
  assign tx_next = s_q.tx_cnt + {4'd0, tx_take} - {4'd0, tx_dec};

  // frames are ignored while the receiver is off, so the error and break flags simply hold
  assign frame_ok = ce & rx_frame & s_q.cfg[`FUS_CFG_RXEN];
  // a second stop bit, when configured, never reaches this block
  assign fe = ~rx_first_stop;
  assign pe = s_q.cfg[`FUS_CFG_PAREN] & (^{rx_data, rx_parity} ^ s_q.cfg[`FUS_CFG_ODD]);
  assign brk_now = frame_ok & (s_q.brk_st == FUS_BRK_FE_SEEN) & fe & (rx_data == 8'h00);
  assign suppress = s_q.brk_st == FUS_BRK_HOLD;

  assign status_view = {fus_sat(pe_cnt), fus_sat(fe_cnt), s_q.flags[7:4], head_fe, head_pe,
                        s_q.flags[1:0]};

  always_comb begin
    set_v = 8'h00;
    set_v[`FUS_B_ER] = frame_ok & (fe | pe);
    set_v[`FUS_B_TX_END_FLAG] = ce & tx_done & (tx_next == 5'd0);
    set_v[`FUS_B_TX_FIFO_LOW_FLAG] = tx_dec & (tx_next <= tx_lvl);
    set_v[`FUS_B_BRK] = brk_now;
    set_v[`FUS_B_RDF] = ce & (rx_cnt >= rx_lvl);
    set_v[`FUS_B_DR] = ce & rx_idle_tick & (rx_cnt != 5'd0) & (rx_cnt < rx_lvl);
  end

  always_comb begin
    clr_v = 8'h00;
    // only armed bits written as 0 clear; a written 1 does nothing
    if (wr_done && (paddr == `FUS_ADDR_STATUS)) begin
      clr_v = s_q.arm & ~pwdata[7:0] & `FUS_CLR_MASK;
    end
    clr_v[`FUS_B_TX_END_FLAG] = clr_v[`FUS_B_TX_END_FLAG] | tx_wr;
    clr_v[`FUS_B_TX_FIFO_LOW_FLAG] = clr_v[`FUS_B_TX_FIFO_LOW_FLAG] | (tx_take & (tx_next > tx_lvl));
  end

  always_comb begin
    s_d = s_q;
    s_d.line_s1 = rx_line;
    s_d.line_s2 = s_q.line_s1;

    s_d.pready = 1'b0;
    if (setup) begin
      s_d.pready = 1'b1;
      s_d.pslverr = ~fus_mapped(paddr);
      unique case (paddr)
        `FUS_ADDR_STATUS: s_d.prdata = {16'h0000, status_view};
        `FUS_ADDR_COUNT: s_d.prdata = {16'h0000, 3'b000, s_q.tx_cnt, 3'b000, rx_cnt};
        `FUS_ADDR_CONFIG: s_d.prdata = {25'h0000000, s_q.cfg};
        `FUS_ADDR_RXDATA: s_d.prdata = {24'h000000, rx_fifo_rdata};
        default: s_d.prdata = 32'h00000000;
      endcase
    end

    if (wr_done && (paddr == `FUS_ADDR_CONFIG)) begin
      s_d.cfg = pwdata[6:0];
    end
    s_d.rx_pop = rd_done & (paddr == `FUS_ADDR_RXDATA);

    s_d.tx_push = tx_take;
    if (tx_take) begin
      s_d.tx_push_data = pwdata[7:0];
    end
    s_d.tx_cnt = tx_next;

    // errored characters are stored too; only a running break holds frames back
    s_d.rx_push = frame_ok & ~suppress;
    if (frame_ok) begin
      s_d.rx_push_data = rx_data;
      s_d.rx_push_fe = fe;
      s_d.rx_push_pe = pe;
    end

    if (frame_ok) begin
      unique case (s_q.brk_st)
        FUS_BRK_IDLE: begin
          if (fe) begin
            s_d.brk_st = FUS_BRK_FE_SEEN;
          end
        end
        FUS_BRK_FE_SEEN: begin
          if (brk_now) begin
            s_d.brk_st = FUS_BRK_HOLD;
          end else if (!fe) begin
            s_d.brk_st = FUS_BRK_IDLE;
          end
        end
        FUS_BRK_HOLD: s_d.brk_st = FUS_BRK_HOLD;
        default: s_d.brk_st = FUS_BRK_IDLE;
      endcase
    end else if (suppress && s_q.line_s2) begin
      // line back at mark: the next character received is stored again
      s_d.brk_st = FUS_BRK_IDLE;
    end

    // a hardware set in the same cycle as a clear wins
    s_d.flags = ((s_q.flags & ~clr_v) | set_v) & `FUS_CLR_MASK;
    // a bit is armed only when it was returned as 1 by a completed status read
    if (rd_done && (paddr == `FUS_ADDR_STATUS)) begin
      s_d.arm = s_q.arm | (s_q.prdata[7:0] & s_q.flags & `FUS_CLR_MASK);
    end
    s_d.arm = s_d.arm & s_d.flags;

    if (standby) begin
      s_d.flags = 8'(`FUS_STATUS_RST);
      s_d.arm = 8'h00;
      s_d.cfg = `FUS_CFG_RST;
      s_d.tx_cnt = 5'd0;
      s_d.brk_st = FUS_BRK_IDLE;
      s_d.tx_push = 1'b0;
      s_d.rx_push = 1'b0;
      s_d.rx_pop = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.flags <= 8'(`FUS_STATUS_RST);
      s_q.cfg <= `FUS_CFG_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign rx_push = s_q.rx_push;
  assign rx_push_data = s_q.rx_push_data;
  assign rx_pop = s_q.rx_pop;
  assign tx_push = s_q.tx_push;
  assign tx_push_data = s_q.tx_push_data;
  assign rx_enable = s_q.cfg[`FUS_CFG_RXEN];
  assign tx_fifo_low = s_q.flags[`FUS_B_TX_FIFO_LOW_FLAG];

  default clocking fus_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_WRITE_ONE_NO_SET: assert property (
    (wr_done && paddr == `FUS_ADDR_STATUS && pwdata[`FUS_B_BRK] && !s_q.flags[`FUS_B_BRK] && !brk_now)
    |=> !s_q.flags[`FUS_B_BRK])
    else $error("break flag set by a software write");

  AST_CLEAR_NEEDS_ARM: assert property (
    $fell(s_q.flags[`FUS_B_ER]) |-> $past(s_q.arm[`FUS_B_ER]) || $past(standby))
    else $error("error flag cleared without an armed read");

  AST_STANDBY_VALUE: assert property (
    (ce && standby) |=> (s_q.flags == 8'h60) && (s_q.arm == 8'h00) && (s_q.tx_cnt == 5'd0))
    else $error("standby did not load the initial status");

  AST_ERROR_SETS: assert property (
    (frame_ok && (fe || pe) && !standby) |=> s_q.flags[`FUS_B_ER] && (s_q.rx_push_fe == $past(fe)))
    else $error("receive error not flagged");

  AST_DISABLED_KEEPS: assert property (
    (ce && !s_q.cfg[`FUS_CFG_RXEN] && !standby && !(wr_done && paddr == `FUS_ADDR_STATUS))
    |=> $stable(s_q.flags[`FUS_B_ER]))
    else $error("error flag moved while receiver off");

  AST_TX_END_FLAG_CLEARS: assert property (
    (tx_wr && !tx_done && !standby) |=> !s_q.flags[`FUS_B_TX_END_FLAG])
    else $error("transmit end not cleared by a data write");

  AST_TX_DISCARD: assert property (
    (tx_wr && s_q.tx_cnt == `FUS_FIFO_DEPTH) |=> !s_q.tx_push)
    else $error("write to a full transmit FIFO was stored");

  AST_TX_FIFO_LOW_FLAG_SETS: assert property (
    (tx_dec && !tx_take && (s_q.tx_cnt - 5'd1) <= tx_lvl && !standby) |=> s_q.flags[`FUS_B_TX_FIFO_LOW_FLAG])
    else $error("transmit low flag missed");

  AST_BREAK_HOLDS: assert property (
    (frame_ok && s_q.brk_st == FUS_BRK_HOLD) |=> !s_q.rx_push)
    else $error("character stored during a break");

  AST_RDF_SETS: assert property (
    (ce && !standby && rx_cnt >= rx_lvl) |=> s_q.flags[`FUS_B_RDF])
    else $error("receive full flag missed");

  // the transmit-end setter and transmit-low clearer below are stated from the transmit count, not from the set or clear vector
  AST_TX_END_FLAG_SETS: assert property (
    (ce && tx_done && s_q.tx_cnt == 5'd0 && !tx_wr && !standby)
    |=> s_q.flags[`FUS_B_TX_END_FLAG])
    else $error("transmit end not set after the last character");

  AST_TX_FIFO_LOW_FLAG_CLEARS: assert property (
    (tx_take && !tx_dec && s_q.tx_cnt >= tx_lvl && !standby)
    |=> !s_q.flags[`FUS_B_TX_FIFO_LOW_FLAG])
    else $error("transmit low flag kept after a refill above trigger");

  AST_TX_COUNT_MAX: assert property (
    ce
    |-> s_q.tx_cnt <= `FUS_FIFO_DEPTH)
    else $error("transmit count beyond the FIFO depth");

  AST_BREAK_SETS: assert property (
    (frame_ok && s_q.brk_st == FUS_BRK_FE_SEEN && !rx_first_stop && rx_data == 8'h00 && !standby)
    |=> s_q.flags[`FUS_B_BRK])
    else $error("break not flagged");

  AST_FRAME_STORED: assert property (
    (frame_ok && s_q.brk_st != FUS_BRK_HOLD && !standby)
    |=> s_q.rx_push && (s_q.rx_push_data == $past(rx_data)))
    else $error("received character not stored");

  AST_ERR_BITS_RO: assert property (
    (wr_done && paddr == `FUS_ADDR_STATUS && !s_q.rx_push && !s_q.rx_pop && !standby)
    |=> $stable({head_fe, head_pe}))
    else $error("framing or parity bit moved by a status write");

  AST_BRK_NEEDS_ARM: assert property (
    (ce && !standby && s_q.flags[`FUS_B_BRK] && !s_q.arm[`FUS_B_BRK])
    |=> s_q.flags[`FUS_B_BRK])
    else $error("break flag cleared without an armed read");

  AST_ERR_COUNT_BOUND: assert property (
    ce
    |-> (fe_cnt <= rx_cnt) && (pe_cnt <= rx_cnt))
    else $error("error count above the receive count");

  // a break ends only once the synchronised line has been seen at mark
  AST_MARK_RESUMES: assert property (
    (ce && !standby && !frame_ok && s_q.brk_st == FUS_BRK_HOLD && s_q.line_s2)
    |=> s_q.brk_st == FUS_BRK_IDLE)
    else $error("break hold not released at mark");

endmodule
`default_nettype wire

// *** design/fus_defs.svh ***
// Register map, field positions, reset values and levels of the serial status-flag block
// What this block does
// - 16-bit status: error counts high, flags low
// - writing 1 never sets a flag
// - clear by writing 0 after reading 1
// - framing and parity bits are read-only
// - reset and standby load 16'h0060
// - error flag on bad stop or parity
// - only the first stop bit is judged
// - receiver disable keeps the error flag
// - errored characters still enter receive FIFO
// - tx end when last bit sent, FIFO empty
// - tx end clears on transmit data write
// - tx low when draining reaches trigger level
// - tx low clears on refill above trigger
// - transmit FIFO holds sixteen bytes
// - transmit writes beyond room are discarded
// - transmit count in count register high byte
// - break: framing error, then zero framing error
// - after break, zero characters are not stored
// - break frame stored; resume after mark, new character
// - error bits follow the character at read-out
// - parity count 15:12, framing count 11:8
// - rx full when count reaches rx trigger
`ifndef FUS_DEFS_SVH
`define FUS_DEFS_SVH

`define FUS_ADDR_STATUS 8'h00
`define FUS_ADDR_COUNT 8'h04
`define FUS_ADDR_CONFIG 8'h08
`define FUS_ADDR_TXDATA 8'h0c
`define FUS_ADDR_RXDATA 8'h10

`define FUS_STATUS_RST 16'h0060
`define FUS_CFG_RST 7'h00
`define FUS_CLR_MASK 8'hf3

`define FUS_B_ER 7
`define FUS_B_TX_END_FLAG 6
`define FUS_B_TX_FIFO_LOW_FLAG 5
`define FUS_B_BRK 4
`define FUS_B_RDF 1
`define FUS_B_DR 0

`define FUS_CFG_RXEN 6
`define FUS_CFG_ODD 5
`define FUS_CFG_PAREN 4

`define FUS_FIFO_DEPTH 5'd16

`define FUS_TTRG_L0 5'd8
`define FUS_TTRG_L1 5'd4
`define FUS_TTRG_L2 5'd2
`define FUS_TTRG_L3 5'd1
`define FUS_RTRG_L0 5'd1
`define FUS_RTRG_L1 5'd4
`define FUS_RTRG_L2 5'd8
`define FUS_RTRG_L3 5'd14

`endif

// *** design/fus_pkg.sv ***
// Types shared by the serial status-flag block
package fus_pkg;

  typedef enum logic [1:0] {
    FUS_BRK_IDLE,
    FUS_BRK_FE_SEEN,
    FUS_BRK_HOLD
  } fus_brk_type;

  typedef struct packed {
    logic line_s1;
    logic line_s2;
    logic [7:0] flags;
    logic [7:0] arm;
    logic [6:0] cfg;
    logic [4:0] tx_cnt;
    fus_brk_type brk_st;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic tx_push;
    logic [7:0] tx_push_data;
    logic rx_push;
    logic [7:0] rx_push_data;
    logic rx_push_fe;
    logic rx_push_pe;
    logic rx_pop;
  } fus_state_type;

  typedef struct packed {
    logic [15:0] fe_mem;
    logic [15:0] pe_mem;
    logic [3:0] rd_ptr;
    logic [3:0] wr_ptr;
    logic [4:0] cnt;
    logic [4:0] fe_cnt;
    logic [4:0] pe_cnt;
  } fus_tag_type;

endpackage

// *** design/fus_err_tags.sv ***
// Error tags of the characters held in the receive FIFO, with running counts
`timescale 1ns/1ps
`default_nettype none
`include "fus_defs.svh"
module fus_err_tags (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic flush,
  input wire logic push,
  input wire logic push_fe,
  input wire logic push_pe,
  input wire logic pop,
  output logic [4:0] count,
  output logic [4:0] fe_count,
  output logic [4:0] pe_count,
  output logic head_fe,
  output logic head_pe
);
  import fus_pkg::*;

  fus_tag_type t_q, t_d;
  logic do_push, do_pop;

  assign do_push = push & (t_q.cnt < `FUS_FIFO_DEPTH);
  assign do_pop = pop & (t_q.cnt != 5'd0);

  always_comb begin
    t_d = t_q;
    if (do_push) begin
      t_d.fe_mem[t_q.wr_ptr] = push_fe;
      t_d.pe_mem[t_q.wr_ptr] = push_pe;
      t_d.wr_ptr = t_q.wr_ptr + 4'd1;
    end
    if (do_pop) begin
      t_d.rd_ptr = t_q.rd_ptr + 4'd1;
    end
    // counts rise with what enters and fall with what the reader takes away
    t_d.cnt = t_q.cnt + {4'd0, do_push} - {4'd0, do_pop};
    t_d.fe_cnt = t_q.fe_cnt + {4'd0, do_push & push_fe} - {4'd0, do_pop & t_q.fe_mem[t_q.rd_ptr]};
    t_d.pe_cnt = t_q.pe_cnt + {4'd0, do_push & push_pe} - {4'd0, do_pop & t_q.pe_mem[t_q.rd_ptr]};
    if (flush) begin
      t_d = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_q <= '0;
    end else if (ce) begin
      t_q <= t_d;
    end
  end

  assign count = t_q.cnt;
  assign fe_count = t_q.fe_cnt;
  assign pe_count = t_q.pe_cnt;
  // an empty FIFO shows no error for the character being read out
  assign head_fe = t_q.fe_mem[t_q.rd_ptr] & (t_q.cnt != 5'd0);
  assign head_pe = t_q.pe_mem[t_q.rd_ptr] & (t_q.cnt != 5'd0);

endmodule
`default_nettype wire

// *** tb/fus_far_model.sv ***
// far-side model: receive FIFO storage and a tally of bytes pushed toward the transmitter
`timescale 1ns/1ps
`default_nettype none
module fus_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rx_push,
  input wire logic [7:0] rx_push_data,
  input wire logic rx_pop,
  input wire logic tx_push,
  input wire logic [7:0] tx_push_data,
  output logic [7:0] rx_fifo_rdata,
  output logic [4:0] rx_cnt,
  output logic [4:0] tx_cnt,
  output logic [7:0] tx_last
);
  logic [7:0] mem [16];
  logic [3:0] rd_q;
  logic [3:0] wr_q;
  logic [7:0] last_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= 4'h0;
      wr_q <= 4'h0;
      rx_cnt <= 5'h00;
      tx_cnt <= 5'h00;
      last_q <= 8'h00;
      tx_last <= 8'h00;
    end else begin
      // errored characters are stored like any other
      if (rx_push && rx_cnt != 5'h10) begin
        mem[wr_q] <= rx_push_data;
        wr_q <= wr_q + 4'h1;
      end
      if (rx_pop && rx_cnt != 5'h00) begin
        last_q <= mem[rd_q];
        rd_q <= rd_q + 4'h1;
      end
      rx_cnt <= rx_cnt + 5'((rx_push && rx_cnt != 5'h10) ? 1 : 0) - 5'((rx_pop && rx_cnt != 5'h00) ? 1 : 0);
      if (tx_push) begin
        tx_cnt <= tx_cnt + 5'h01;
        tx_last <= tx_push_data;
      end
    end
  end
  // an empty FIFO shows no stale byte: the inverse of the last one read instead
  assign rx_fifo_rdata = (rx_cnt != 5'h00) ? mem[rd_q] : ~last_q;
endmodule
`default_nettype wire

// *** tb/fus_status_tb.sv ***
// self-checking bench for the serial status-flag block
`timescale 1ns/1ps
`default_nettype none
`include "fus_defs.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, (got), (exp)); end end
module fus_status_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic standby = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rx_line = 1'b1;
  logic rx_frame = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic rx_parity = 1'b0;
  logic rx_first_stop = 1'b1;
  logic rx_idle_tick = 1'b0;
  logic [7:0] rx_fifo_rdata;
  logic rx_push;
  logic [7:0] rx_push_data;
  logic rx_pop;
  logic tx_load = 1'b0;
  logic tx_done = 1'b0;
  logic tx_push;
  logic [7:0] tx_push_data;
  logic rx_enable;
  logic tx_fifo_low;
  logic [4:0] m_rx_cnt;
  logic [4:0] m_tx_cnt;
  logic [7:0] m_tx_last;
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;

  always #2 pclk = ~pclk;

  fus_status u_fus_status (.pclk(pclk), .presetn(presetn), .ce(1'b1), .standby(standby), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_line(rx_line), .rx_frame(rx_frame), .rx_data(rx_data), .rx_parity(rx_parity),
    .rx_first_stop(rx_first_stop), .rx_idle_tick(rx_idle_tick), .rx_fifo_rdata(rx_fifo_rdata),
    .rx_push(rx_push), .rx_push_data(rx_push_data), .rx_pop(rx_pop), .tx_load(tx_load), .tx_done(tx_done),
    .tx_push(tx_push), .tx_push_data(tx_push_data), .rx_enable(rx_enable), .tx_fifo_low(tx_fifo_low));

  fus_far_model u_fus_far_model (.pclk(pclk), .presetn(presetn), .rx_push(rx_push),
    .rx_push_data(rx_push_data), .rx_pop(rx_pop), .tx_push(tx_push), .tx_push_data(tx_push_data),
    .rx_fifo_rdata(rx_fifo_rdata), .rx_cnt(m_rx_cnt), .tx_cnt(m_tx_cnt), .tx_last(m_tx_last));

  task automatic complete_run();
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one APB transfer; entered just after an edge, leaves one idle edge behind it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench timeout ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    `CHK(rd, exp)
  endtask

  // one received character, then three edges for the flags and tags to land
  task automatic frame(input logic [7:0] d, input logic p, input logic s);
    rx_frame <= 1'b1;
    rx_data <= d;
    rx_parity <= p;
    rx_first_stop <= s;
    @(posedge pclk);
    rx_frame <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic loads(input int n);
    repeat (n) begin
      tx_load <= 1'b1;
      @(posedge pclk);
      tx_load <= 1'b0;
      @(posedge pclk);
    end
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // nothing read yet: writes of 0 must not clear
    apb(1'b1, `FUS_ADDR_STATUS, 32'h0);
    apb(1'b1, `FUS_ADDR_STATUS, 32'h0);
    chk_reg(`FUS_ADDR_STATUS, 32'h0060);
    apb(1'b0, 8'h14, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(1'b1, 8'h14, 32'h0);
    `CHK(err, 1'b1)
    chk_reg(`FUS_ADDR_STATUS, 32'h0060);
    apb(1'b1, `FUS_ADDR_STATUS, 32'hffff);
    chk_reg(`FUS_ADDR_STATUS, 32'h0060);
    apb(1'b1, `FUS_ADDR_STATUS, 32'h0);
    chk_reg(`FUS_ADDR_STATUS, 32'h0000);
    // two writes past a full transmit FIFO must vanish
    repeat (18) apb(1'b1, `FUS_ADDR_TXDATA, 32'h000000a5);
    chk_reg(`FUS_ADDR_COUNT, 32'h00001000);
    `CHK(m_tx_cnt, 5'd16)
    loads(7);
    chk_reg(`FUS_ADDR_STATUS, 32'h0000);
    loads(1);
    chk_reg(`FUS_ADDR_STATUS, 32'h0020);
    `CHK(tx_fifo_low, 1'b1)
    loads(8);
    tx_done <= 1'b1;
    @(posedge pclk);
    tx_done <= 1'b0;
    @(posedge pclk);
    chk_reg(`FUS_ADDR_STATUS, 32'h0060);
    apb(1'b1, `FUS_ADDR_TXDATA, 32'h0000005a);
    chk_reg(`FUS_ADDR_STATUS, 32'h0020);
    repeat (8) apb(1'b1, `FUS_ADDR_TXDATA, 32'h0000005a);
    chk_reg(`FUS_ADDR_STATUS, 32'h0000);
    `CHK(m_tx_last, 8'h5a)
    standby <= 1'b1;
    @(posedge pclk);
    standby <= 1'b0;
    @(posedge pclk);
    chk_reg(`FUS_ADDR_STATUS, 32'h0060);
    chk_reg(`FUS_ADDR_COUNT, 32'h0);
    // receiver on, even parity, rx trigger 1
    apb(1'b1, `FUS_ADDR_CONFIG, 32'h50);
    frame(8'h55, 1'b0, 1'b1);
    frame(8'h01, 1'b0, 1'b1);
    frame(8'h03, 1'b0, 1'b0);
    `CHK(m_rx_cnt, 5'd3)
    chk_reg(`FUS_ADDR_STATUS, 32'h11e2);
    chk_reg(`FUS_ADDR_RXDATA, 32'h55);
    repeat (2) @(posedge pclk);
    chk_reg(`FUS_ADDR_STATUS, 32'h11e6);
    chk_reg(`FUS_ADDR_RXDATA, 32'h01);
    repeat (2) @(posedge pclk);
    chk_reg(`FUS_ADDR_STATUS, 32'h01ea);
    chk_reg(`FUS_ADDR_RXDATA, 32'h03);
    repeat (2) @(posedge pclk);
    chk_reg(`FUS_ADDR_STATUS, 32'h00e2);
    apb(1'b1, `FUS_ADDR_CONFIG, 32'h10);
    `CHK(rx_enable, 1'b0)
    frame(8'h01, 1'b0, 1'b0);
    `CHK(m_rx_cnt, 5'd0)
    chk_reg(`FUS_ADDR_STATUS, 32'h00e2);
    apb(1'b1, `FUS_ADDR_CONFIG, 32'h5c);
    frame(8'h11, 1'b0, 1'b1);
    rx_idle_tick <= 1'b1;
    @(posedge pclk);
    rx_idle_tick <= 1'b0;
    @(posedge pclk);
    chk_reg(`FUS_ADDR_STATUS, 32'h00e3);
    chk_reg(`FUS_ADDR_RXDATA, 32'h11);
    // line held at space: a break, then mark again
    apb(1'b1, `FUS_ADDR_CONFIG, 32'h50);
    rx_line <= 1'b0;
    repeat (3) frame(8'h00, 1'b0, 1'b0);
    `CHK(m_rx_cnt, 5'd2)
    rx_line <= 1'b1;
    repeat (5) @(posedge pclk);
    frame(8'h7e, 1'b0, 1'b1);
    `CHK(m_rx_cnt, 5'd3)
    chk_reg(`FUS_ADDR_STATUS, 32'h02fb);
    apb(1'b1, `FUS_ADDR_STATUS, 32'h007f);
    chk_reg(`FUS_ADDR_STATUS, 32'h027b);
    // odd parity: 0x01 with parity bit 1 has an even count of ones
    apb(1'b1, `FUS_ADDR_CONFIG, 32'h70);
    frame(8'h01, 1'b1, 1'b1);
    chk_reg(`FUS_ADDR_STATUS, 32'h12fb);
    complete_run();
  end
endmodule
`default_nettype wire
